// ==== lcdcmd_defs.vh ====
// Shared constants of the display controller command unit
`ifndef LCDCMD_DEFS_VH
`define LCDCMD_DEFS_VH

// Clock period and instruction execution time
`define LC_CLK_NS 100
`define LC_T_EXEC_NS 37000
`define LC_EXEC_CYC ((`LC_T_EXEC_NS + `LC_CLK_NS - 1) / `LC_CLK_NS)

// Instruction opcode bits, highest set bit wins
`define LC_B_DDA 7
`define LC_B_CGA 6
`define LC_B_FN 5
`define LC_B_SH 4
`define LC_B_DC 3
`define LC_B_EM 2
`define LC_B_HOME 1
`define LC_B_CLR 0

// Instruction field bits
`define LC_F_DL 4
`define LC_F_N 3
`define LC_F_F 2
`define LC_F_SC 3
`define LC_F_RL 2
`define LC_F_D 2
`define LC_F_C 1
`define LC_F_B 0
`define LC_F_ID 1
`define LC_F_S 0

// Display RAM address map
`define LC_AC_ZERO 7'h00
`define LC_DD_LAST1 7'h4f
`define LC_L1_LAST 7'h27
`define LC_L2_FIRST 7'h40
`define LC_L2_LAST 7'h67
`define LC_SPACE 8'h20

// Display shift span per line
`define LC_SHIFT_W1 7'h50
`define LC_SHIFT_W2 7'h28

// Drive configuration codes
`define LC_DUTY_8 2'h0
`define LC_DUTY_11 2'h1
`define LC_DUTY_16 2'h2
`define LC_COM_8 5'h08
`define LC_COM_11 5'h0b
`define LC_COM_16 5'h10
`define LC_DIG_1 5'h08
`define LC_DIG_2 5'h10

`endif

// ==== lcdcmd_ram.v ====
// Single-port-write, registered-read RAM for display and pattern data
`timescale 1ns/1ps
`default_nettype none
module lcdcmd_ram #(
  parameter AW = 7,
  parameter DW = 8
) (
  // Clock
  input wire clk,
  // Write port
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  // Read port
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata_q
);
  // Storage, no reset so it maps onto plain RAM
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Write and registered read
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule
`default_nettype wire

// ==== lcdcmd_nib.v ====
// Nibble assembler for the 4-bit and 8-bit host transfer modes
`timescale 1ns/1ps
`default_nettype none
module lcdcmd_nib (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Mode
  input wire width8,
  // Host access
  input wire wr,
  input wire rd,
  input wire [7:0] wdata,
  // Assembled access
  output wire done,
  output wire [7:0] word,
  output reg phase_q
);
  // Upper nibble held from the first half of a 4-bit write
  reg [3:0] hold_q;

  // A transfer ends on every 8-bit access or the second nibble
  assign done = (wr | rd) & (width8 | phase_q);
  assign word = width8 ? wdata : {hold_q, wdata[7:4]};

  // Phase toggles on reads and writes alike, status checks too
  always @(posedge clk) begin
    if (srst) begin
      phase_q <= 1'b0;
      hold_q <= 4'h0;
    end else if (width8) begin
      phase_q <= 1'b0;
    end else if (wr | rd) begin
      phase_q <= ~phase_q;
      if (wr & ~phase_q) begin
        hold_q <= wdata[7:4];
      end
    end
  end
endmodule
`default_nettype wire

// ==== lcdcmd_top.v ====
// Instruction interpreter of a character display controller
//
// Overview of operation
// - Status read returns busy flag and counter
// - Instructions ignored while busy is set
// - One counter addresses both RAMs
// - Cursor shift steps counter down or up
// - Display shift moves view, cursor follows
// - Lines and font choose duty 8/11/16
// - Two lines force the small font
// - Drive 8, 11 or 16 commons
// - Data write goes to selected RAM
// - Write steps counter, may shift display
// - Read steps counter, never shifts display
// - Back-to-back reads all return fresh data
// - Read right after write is stale
// - Cursor shift sets up display reads
// - 4-bit mode uses two cycles each
// - Unused commons drive non-selection
// - Digit count of 8 or 16
// - Width select picks 8 or 4 lines
// - Entry direction steps counter by one
`timescale 1ns/1ps
`default_nettype none
`include "lcdcmd_defs.vh"
module lcdcmd_top #(
  parameter EXEC_CYCLES = `LC_EXEC_CYC,
  parameter CW = 9
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Host port
  input wire register_select,
  input wire [7:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [7:0] bus_rdata_q,
  // Status
  output reg busy_indicator_q,
  output reg [6:0] ram_address_counter_q,
  output reg pattern_ram_sel_q,
  output reg interface_width_select_q,
  // Display control
  output reg display_on_q,
  output reg cursor_on_q,
  output reg blink_on_q,
  output reg [6:0] display_shift_q,
  // Drive configuration
  output reg two_line_q,
  output reg tall_font_q,
  output reg [1:0] duty_sel_q,
  output reg [4:0] common_count_q,
  output reg [15:0] common_active_q,
  output reg [4:0] digit_count_q
);
  // Last count of the busy period
  localparam integer EXEC_LAST_I = EXEC_CYCLES - 1;
  localparam [CW-1:0] EXEC_LAST = EXEC_LAST_I[CW-1:0];

  // Entry mode
  reg step_up_q; // Counter direction
  reg entry_shift_q; // Shift display on write
  // Busy timer
  reg [CW-1:0] busy_cnt_q;
  // Read prefetch pipeline and latch
  reg pf1_q;
  reg pf2_q;
  reg [7:0] read_latch_q;
  // Clear sweep
  reg clr_q;
  reg [6:0] sweep_q;

  // Assembled host access
  wire acc_done;
  wire [7:0] acc_word;
  wire nib_phase;
  // RAM read data
  wire [7:0] dd_rdata;
  wire [7:0] cg_rdata;

  // Accepted instruction or data transfer
  wire take_wr = acc_done & bus_wr & ~busy_indicator_q;
  wire take_rd = acc_done & bus_rd & register_select & ~busy_indicator_q;
  wire take_cmd = take_wr & ~register_select;
  wire take_data = take_wr & register_select;
  wire in_dd = ~pattern_ram_sel_q;

  // RAM write controls; clear sweep owns display RAM while it runs
  wire dd_we = clr_q | (take_data & in_dd);
  wire [6:0] dd_waddr = clr_q ? sweep_q : ram_address_counter_q;
  wire [7:0] dd_wdata = clr_q ? `LC_SPACE : acc_word;
  wire cg_we = take_data & pattern_ram_sel_q;

  // Counter step with line wrap of the display RAM map
  function [6:0] ac_step;
    input [6:0] a;
    input up;
    input dd;
    input two;
    begin
      if (!dd) begin
        // Pattern RAM wraps within six bits
        ac_step = {1'b0, up ? a[5:0] + 6'h01 : a[5:0] - 6'h01};
      end else if (two) begin
        // Two lines skip the hole between the lines
        if (up) begin
          ac_step = (a == `LC_L1_LAST) ? `LC_L2_FIRST :
                    (a == `LC_L2_LAST) ? `LC_AC_ZERO : a + 7'h01;
        end else begin
          ac_step = (a == `LC_AC_ZERO) ? `LC_L2_LAST :
                    (a == `LC_L2_FIRST) ? `LC_L1_LAST : a - 7'h01;
        end
      end else begin
        // One line spans the whole display RAM
        if (up) begin
          ac_step = (a == `LC_DD_LAST1) ? `LC_AC_ZERO : a + 7'h01;
        end else begin
          ac_step = (a == `LC_AC_ZERO) ? `LC_DD_LAST1 : a - 7'h01;
        end
      end
    end
  endfunction

  // Display offset step; each line wraps on its own
  function [6:0] sh_step;
    input [6:0] o;
    input left;
    input two;
    reg [6:0] span;
    begin
      span = two ? `LC_SHIFT_W2 : `LC_SHIFT_W1;
      if (left) begin
        sh_step = (o == span - 7'h01) ? `LC_AC_ZERO : o + 7'h01;
      end else begin
        sh_step = (o == `LC_AC_ZERO) ? span - 7'h01 : o - 7'h01;
      end
    end
  endfunction

  // Host nibble assembly
  lcdcmd_nib u_nib (
    .clk(clk),
    .srst(srst),
    .width8(interface_width_select_q),
    .wr(bus_wr),
    .rd(bus_rd),
    .wdata(bus_wdata),
    .done(acc_done),
    .word(acc_word),
    .phase_q(nib_phase)
  );

  // Display RAM
  lcdcmd_ram #(.AW(7), .DW(8)) u_dd (
    .clk(clk),
    .we(dd_we),
    .waddr(dd_waddr),
    .wdata(dd_wdata),
    .raddr(ram_address_counter_q),
    .rdata_q(dd_rdata)
  );

  // Pattern RAM
  lcdcmd_ram #(.AW(6), .DW(8)) u_cg (
    .clk(clk),
    .we(cg_we),
    .waddr(ram_address_counter_q[5:0]),
    .wdata(acc_word),
    .raddr(ram_address_counter_q[5:0]),
    .rdata_q(cg_rdata)
  );

  // Busy timer; raised on acceptance, dropped after execution time
  always @(posedge clk) begin
    if (srst) begin
      busy_indicator_q <= 1'b0;
      busy_cnt_q <= {CW{1'b0}};
    end else if (take_wr | take_rd) begin
      busy_indicator_q <= 1'b1;
      busy_cnt_q <= {CW{1'b0}};
    end else if (busy_indicator_q) begin
      // Count out the fixed execution time
      if (busy_cnt_q == EXEC_LAST) begin
        busy_indicator_q <= 1'b0;
      end else begin
        busy_cnt_q <= busy_cnt_q + 1'b1;
      end
    end
  end

  // Instruction execution; effects land at the accept edge
  always @(posedge clk) begin
    if (srst) begin
      ram_address_counter_q <= `LC_AC_ZERO;
      pattern_ram_sel_q <= 1'b0;
      interface_width_select_q <= 1'b1;
      two_line_q <= 1'b0;
      tall_font_q <= 1'b0;
      step_up_q <= 1'b1;
      entry_shift_q <= 1'b0;
      display_on_q <= 1'b0;
      cursor_on_q <= 1'b0;
      blink_on_q <= 1'b0;
      display_shift_q <= `LC_AC_ZERO;
      pf1_q <= 1'b0;
      clr_q <= 1'b0;
      sweep_q <= `LC_AC_ZERO;
    end else begin
      pf1_q <= 1'b0;
      // Clear sweep writes blanks over display RAM addresses 00h to 4Fh
      if (clr_q) begin
        if (sweep_q == `LC_DD_LAST1) begin
          clr_q <= 1'b0;
        end else begin
          sweep_q <= sweep_q + 7'h01;
        end
      end
      if (take_data) begin
        // Write steps the counter; display shift only for display RAM
        ram_address_counter_q <= ac_step(ram_address_counter_q, step_up_q, in_dd, two_line_q);
        if (entry_shift_q & in_dd) begin
          display_shift_q <= sh_step(display_shift_q, step_up_q, two_line_q);
        end
      end else if (take_rd) begin
        // Read steps the counter and refetches, never shifts
        ram_address_counter_q <= ac_step(ram_address_counter_q, step_up_q, in_dd, two_line_q);
        pf1_q <= 1'b1;
      end else if (take_cmd) begin
        if (acc_word[`LC_B_DDA]) begin
          // Display address set, shared counter
          ram_address_counter_q <= acc_word[6:0];
          pattern_ram_sel_q <= 1'b0;
          pf1_q <= 1'b1;
        end else if (acc_word[`LC_B_CGA]) begin
          // Pattern address set, shared counter
          ram_address_counter_q <= {1'b0, acc_word[5:0]};
          pattern_ram_sel_q <= 1'b1;
          pf1_q <= 1'b1;
        end else if (acc_word[`LC_B_FN]) begin
          // Width, lines and font
          interface_width_select_q <= acc_word[`LC_F_DL];
          two_line_q <= acc_word[`LC_F_N];
          tall_font_q <= acc_word[`LC_F_F] & ~acc_word[`LC_F_N];
        end else if (acc_word[`LC_B_SH]) begin
          if (acc_word[`LC_F_SC]) begin
            // View moves; counter untouched so the cursor rides along
            display_shift_q <= sh_step(display_shift_q, ~acc_word[`LC_F_RL], two_line_q);
          end else begin
            // Cursor moves and acts as an address set for reads
            ram_address_counter_q <= ac_step(ram_address_counter_q, acc_word[`LC_F_RL], in_dd, two_line_q);
            pf1_q <= 1'b1;
          end
        end else if (acc_word[`LC_B_DC]) begin
          // Display, cursor and blink enables
          display_on_q <= acc_word[`LC_F_D];
          cursor_on_q <= acc_word[`LC_F_C];
          blink_on_q <= acc_word[`LC_F_B];
        end else if (acc_word[`LC_B_EM]) begin
          // Entry mode
          step_up_q <= acc_word[`LC_F_ID];
          entry_shift_q <= acc_word[`LC_F_S];
        end else if (acc_word[`LC_B_HOME]) begin
          // Home: counter and view back to origin
          ram_address_counter_q <= `LC_AC_ZERO;
          pattern_ram_sel_q <= 1'b0;
          display_shift_q <= `LC_AC_ZERO;
        end else if (acc_word[`LC_B_CLR]) begin
          // Clear: blank display RAM 00h to 4Fh, origin, increment mode
          ram_address_counter_q <= `LC_AC_ZERO;
          pattern_ram_sel_q <= 1'b0;
          display_shift_q <= `LC_AC_ZERO;
          step_up_q <= 1'b1;
          clr_q <= 1'b1;
          sweep_q <= `LC_AC_ZERO;
        end
      end
    end
  end

  // Read prefetch; RAM output settles one cycle after the counter.
  // A data write does not refetch, so the latch goes stale on purpose.
  always @(posedge clk) begin
    if (srst) begin
      pf2_q <= 1'b0;
      read_latch_q <= 8'h00;
    end else begin
      pf2_q <= pf1_q;
      if (pf2_q) begin
        read_latch_q <= pattern_ram_sel_q ? cg_rdata : dd_rdata;
      end
    end
  end

  // Read answer, valid only in the cycle after the strobe
  always @(posedge clk) begin
    if (srst) begin
      bus_rdata_q <= 8'h00;
    end else if (bus_rd) begin
      if (register_select) begin
        // Data read returns the latch, high nibble first in 4-bit mode
        if (interface_width_select_q) begin
          bus_rdata_q <= read_latch_q;
        end else if (nib_phase) begin
          bus_rdata_q <= {read_latch_q[3:0], 4'h0};
        end else begin
          bus_rdata_q <= {read_latch_q[7:4], 4'h0};
        end
      end else begin
        // Status read; answered even while busy
        if (interface_width_select_q) begin
          bus_rdata_q <= {busy_indicator_q, ram_address_counter_q};
        end else if (nib_phase) begin
          bus_rdata_q <= {ram_address_counter_q[3:0], 4'h0};
        end else begin
          bus_rdata_q <= {busy_indicator_q, ram_address_counter_q[6:4], 4'h0};
        end
      end
    end else begin
      bus_rdata_q <= 8'h00;
    end
  end

  // Duty, common and digit counts follow the line and font choice
  always @(posedge clk) begin
    if (srst) begin
      duty_sel_q <= `LC_DUTY_8;
      common_count_q <= `LC_COM_8;
      digit_count_q <= `LC_DIG_1;
    end else if (two_line_q) begin
      duty_sel_q <= `LC_DUTY_16;
      common_count_q <= `LC_COM_16;
      digit_count_q <= `LC_DIG_2;
    end else if (tall_font_q) begin
      duty_sel_q <= `LC_DUTY_11;
      common_count_q <= `LC_COM_11;
      digit_count_q <= `LC_DIG_1;
    end else begin
      duty_sel_q <= `LC_DUTY_8;
      common_count_q <= `LC_COM_8;
      digit_count_q <= `LC_DIG_1;
    end
  end

  // Per-common activity; a low bit means non-selection waveform
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_com
      always @(posedge clk) begin
        if (srst) begin
          common_active_q[gi] <= 1'b0;
        end else begin
          common_active_q[gi] <= (gi < common_count_q);
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== lcdcmd_monitor.sv ====
// Port checker of the display command unit
`timescale 1ns/1ps
`default_nettype none
`include "lcdcmd_defs.vh"
module lcdcmd_monitor #(
  parameter EXEC_CYCLES = 370
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Host port
  input wire register_select,
  input wire [7:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  input wire [7:0] bus_rdata_q,
  // Status
  input wire busy_indicator_q,
  input wire [6:0] ram_address_counter_q,
  input wire interface_width_select_q,
  input wire [6:0] display_shift_q,
  // Drive configuration
  input wire two_line_q,
  input wire tall_font_q,
  input wire [1:0] duty_sel_q,
  input wire [4:0] common_count_q,
  input wire [15:0] common_active_q,
  input wire [4:0] digit_count_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Busy cycles seen so far, cleared whenever idle
  logic [15:0] busy_cnt_q;
  always_ff @(posedge clk) begin
    busy_cnt_q <= (srst || !busy_indicator_q) ? 16'h0000 : busy_cnt_q + 16'h0001;
  end
  // Instruction that the device must take
  sequence s_instr;
    bus_wr && !register_select && !busy_indicator_q && interface_width_select_q;
  endsequence
  // Cursor move, kept clear of the wrap points
  sequence s_cursor;
    s_instr ##0 (bus_wdata[7:3] == 5'h02) ##0 (ram_address_counter_q inside {[7'h01:7'h26]});
  endsequence
  // Whole view shift
  sequence s_dshift;
    s_instr ##0 (bus_wdata[7:3] == 5'h03);
  endsequence
  // Status read in full width
  sequence s_status;
    bus_rd && !register_select && interface_width_select_q;
  endsequence
  a_status_word: assert property (s_status |=> bus_rdata_q == {$past(busy_indicator_q), $past(ram_address_counter_q)})
    else $error("status word wrong");
  a_busy_refuse: assert property (bus_wr && busy_indicator_q && interface_width_select_q |=> $stable(ram_address_counter_q))
    else $error("busy write took effect");
  a_busy_start: assert property (s_instr |=> busy_indicator_q)
    else $error("busy not raised");
  a_busy_span: assert property ($fell(busy_indicator_q) |-> $past(busy_cnt_q) == EXEC_CYCLES - 1)
    else $error("busy span wrong");
  a_cursor_step: assert property (s_cursor |=> ram_address_counter_q == ($past(bus_wdata[2]) ?
    $past(ram_address_counter_q) + 7'h01 : $past(ram_address_counter_q) - 7'h01))
    else $error("cursor step wrong");
  a_view_keeps_ac: assert property (s_dshift |=> $stable(ram_address_counter_q))
    else $error("view shift moved counter");
  a_view_moves: assert property (s_dshift |=> display_shift_q != $past(display_shift_q))
    else $error("view shift did not move");
  a_duty_map: assert property (duty_sel_q == ($past(two_line_q) ? `LC_DUTY_16 :
    ($past(tall_font_q) ? `LC_DUTY_11 : `LC_DUTY_8)))
    else $error("duty wrong");
  a_font_forced: assert property (two_line_q |-> !tall_font_q)
    else $error("tall font with two lines");
  a_common_cnt: assert property (common_count_q == ($past(two_line_q) ? `LC_COM_16 :
    ($past(tall_font_q) ? `LC_COM_11 : `LC_COM_8)))
    else $error("common count wrong");
  a_digit_cnt: assert property (digit_count_q == ($past(two_line_q) ? `LC_DIG_2 : `LC_DIG_1))
    else $error("digit count wrong");
  a_unused_com: assert property (!$past(srst) |->
    common_active_q == 16'((17'h00001 << $past(common_count_q)) - 17'h00001))
    else $error("unused commons selected");
endmodule
`default_nettype wire

// ==== lcdcmd_host.sv ====
// Host processor model on the parallel port
`timescale 1ns/1ps
`default_nettype none
module lcdcmd_host (
  // Clock and read data
  input wire logic clk,
  input wire logic [7:0] bus_rdata_q,
  // Host drive
  output logic register_select,
  output logic [7:0] bus_wdata,
  output logic bus_wr,
  output logic bus_rd
);
  // Host view of the transfer width
  logic w8 = 1'b1;
  // Idle port at time zero
  initial begin
    register_select = 1'b0;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end
  // One strobe; data lines flip once let go so stale values never pass
  task automatic strobe(input logic rs, input logic rd, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    register_select <= rs;
    bus_wdata <= d;
    bus_wr <= !rd;
    bus_rd <= rd;
    @(posedge clk);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    bus_wdata <= ~d;
    #1 q = bus_rdata_q;
  endtask
  // Whole write, high nibble first in narrow mode
  task automatic put(input logic rs, input logic [7:0] d);
    logic [7:0] q;
    strobe(rs, 1'b0, d, q);
    if (!w8) strobe(rs, 1'b0, {d[3:0], 4'h0}, q);
  endtask
  // Whole read, two strobes in narrow mode
  task automatic get(input logic rs, output logic [7:0] q);
    logic [7:0] h;
    strobe(rs, 1'b1, 8'h00, h);
    q = h;
    if (!w8) begin
      strobe(rs, 1'b1, 8'h00, q);
      q = {h[7:4], q[7:4]};
    end
  endtask
  // Poll busy, bounded, before any further write
  task automatic ready(output logic [7:0] s);
    s = 8'hff;
    for (int i = 0; i < 300 && s[7] !== 1'b0; i++) get(1'b0, s);
  endtask
endmodule
`default_nettype wire

// ==== lcd_ctrl_mpu_command_unit_tb.sv ====
// Self-checking bench of the display command unit
`timescale 1ns/1ps
`default_nettype none
`include "lcdcmd_defs.vh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module lcd_ctrl_mpu_command_unit_tb;
  // Short busy span keeps the run brief
  localparam int EXEC = 100;
  logic clk = 1'b0;
  logic srst = 1'b1;
  wire register_select, bus_wr, bus_rd, busy_indicator_q, pattern_ram_sel_q, interface_width_select_q;
  wire display_on_q, cursor_on_q, blink_on_q, two_line_q, tall_font_q;
  wire [7:0] bus_wdata, bus_rdata_q;
  wire [6:0] ram_address_counter_q, display_shift_q;
  wire [1:0] duty_sel_q;
  wire [4:0] common_count_q, digit_count_q;
  wire [15:0] common_active_q;
  int err_total = 0;
  int num_checks = 0;
  int seed;
  logic [7:0] s, q;
  logic [7:0] d [4];
  logic [6:0] base, sh, ac0;
  // 10 MHz clock
  always #50 clk = ~clk;
  lcdcmd_top #(.EXEC_CYCLES(EXEC)) u_lcdcmd_top (.clk(clk), .srst(srst), .register_select(register_select),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_q(bus_rdata_q),
    .busy_indicator_q(busy_indicator_q), .ram_address_counter_q(ram_address_counter_q),
    .pattern_ram_sel_q(pattern_ram_sel_q), .interface_width_select_q(interface_width_select_q),
    .display_on_q(display_on_q), .cursor_on_q(cursor_on_q), .blink_on_q(blink_on_q),
    .display_shift_q(display_shift_q), .two_line_q(two_line_q), .tall_font_q(tall_font_q),
    .duty_sel_q(duty_sel_q), .common_count_q(common_count_q), .common_active_q(common_active_q),
    .digit_count_q(digit_count_q));
  lcdcmd_host u_lcdcmd_host (.clk(clk), .bus_rdata_q(bus_rdata_q), .register_select(register_select),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd));
  // Commons expected for a line and font code {N,F}
  function automatic logic [4:0] com_exp(input int i);
    return i > 1 ? `LC_COM_16 : (i == 1 ? `LC_COM_11 : `LC_COM_8);
  endfunction
  // Verdict and end of run
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Write then wait for busy to clear
  task automatic wi(input logic rs, input logic [7:0] v);
    u_lcdcmd_host.put(rs, v);
    u_lcdcmd_host.ready(s);
    `CHK("ready", 1'b0, s[7])
  endtask
  // Main sequence
  initial begin
    seed = $urandom(32'ha39ec0b9);
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("busy", 1'b0, busy_indicator_q)
    `CHK("ac", 7'h00, ram_address_counter_q)
    // Every line and font pairing, ending in one line small font
    for (int i = 3; i >= 0; i--) begin
      wi(1'b0, 8'h30 | 8'(i << 2));
      `CHK("tall", 1'(i == 1), tall_font_q)
      `CHK("duty", i > 1 ? `LC_DUTY_16 : (i == 1 ? `LC_DUTY_11 : `LC_DUTY_8), duty_sel_q)
      `CHK("coms", com_exp(i), common_count_q)
      `CHK("active", 16'((17'h1 << com_exp(i)) - 17'h1), common_active_q)
      `CHK("digits", i > 1 ? `LC_DIG_2 : `LC_DIG_1, digit_count_q)
    end
    // Status at once, then an instruction sent while busy
    u_lcdcmd_host.put(1'b0, 8'h85);
    u_lcdcmd_host.get(1'b0, q);
    `CHK("status", 8'h85, q)
    u_lcdcmd_host.put(1'b0, 8'h90);
    u_lcdcmd_host.ready(s);
    `CHK("refused", 8'h05, s)
    // Random bytes written upward, then read back
    base = 7'(1 + $urandom % 32);
    wi(1'b0, 8'h06);
    wi(1'b0, {1'b1, base});
    for (int k = 0; k < 4; k++) begin
      d[k] = 8'($urandom);
      wi(1'b1, d[k]);
      `CHK("ac up", base + 7'(k + 1), ram_address_counter_q)
    end
    wi(1'b0, {1'b1, base});
    for (int k = 0; k < 4; k++) begin
      u_lcdcmd_host.get(1'b1, q);
      u_lcdcmd_host.ready(s);
      `CHK("rdata", d[k], q)
      `CHK("ac rd", base + 7'(k + 1), ram_address_counter_q)
    end
    // Step down, then a write that shifts the view
    sh = display_shift_q;
    wi(1'b0, 8'h04);
    wi(1'b1, 8'($urandom));
    `CHK("ac dn", base + 7'h3, ram_address_counter_q)
    wi(1'b0, 8'h07);
    wi(1'b1, 8'($urandom));
    `CHK("shift wr", sh + 7'h1, display_shift_q)
    // All four shift codes
    for (int j = 0; j < 4; j++) begin
      ac0 = ram_address_counter_q;
      sh = display_shift_q;
      wi(1'b0, 8'h10 | 8'(j << 2));
      `CHK("sh ac", j < 2 ? (j == 1 ? ac0 + 7'h1 : ac0 - 7'h1) : ac0, ram_address_counter_q)
      `CHK("sh view", j < 2 ? sh : (j == 2 ? sh + 7'h1 : sh - 7'h1), display_shift_q)
    end
    // Cursor shift sets up the read address
    wi(1'b0, {1'b1, base + 7'h1});
    wi(1'b0, 8'h10);
    sh = display_shift_q;
    u_lcdcmd_host.get(1'b1, q);
    u_lcdcmd_host.ready(s);
    `CHK("cur rd", d[0], q)
    `CHK("no shift", sh, display_shift_q)
    // Pattern RAM: write, readdress, overwrite, then a read that must be stale
    wi(1'b0, 8'h45);
    `CHK("cg sel", 1'b1, pattern_ram_sel_q)
    wi(1'b1, d[2]);
    wi(1'b0, 8'h45);
    wi(1'b1, d[3]);
    u_lcdcmd_host.get(1'b1, q);
    u_lcdcmd_host.ready(s);
    `CHK("stale rd", d[2], q)
    `CHK("cg ac", 8'h07, s)
    // Display enables, second one sent while busy
    u_lcdcmd_host.put(1'b0, 8'h0d);
    u_lcdcmd_host.put(1'b0, 8'h0f);
    u_lcdcmd_host.ready(s);
    `CHK("disp on", 1'b1, display_on_q)
    `CHK("cursor on", 1'b0, cursor_on_q)
    `CHK("blink on", 1'b1, blink_on_q)
    // Home brings counter, RAM choice and view back
    wi(1'b0, 8'h02);
    `CHK("home ac", 7'h00, ram_address_counter_q)
    `CHK("home sel", 1'b0, pattern_ram_sel_q)
    `CHK("home view", 7'h00, display_shift_q)
    // Clear blanks display RAM and forces upward stepping
    wi(1'b0, 8'h04);
    wi(1'b0, 8'h01);
    wi(1'b0, {1'b1, base});
    u_lcdcmd_host.get(1'b1, q);
    u_lcdcmd_host.ready(s);
    `CHK("blank", `LC_SPACE, q)
    `CHK("clr up", 8'(base + 7'h1), s)
    // Narrow transfers: status, write and read in nibble pairs
    u_lcdcmd_host.put(1'b0, 8'h20);
    u_lcdcmd_host.w8 = 1'b0;
    u_lcdcmd_host.ready(s);
    `CHK("width4", 1'b0, interface_width_select_q)
    wi(1'b0, 8'h92);
    `CHK("stat4", 8'h12, s)
    d[1] = 8'($urandom);
    wi(1'b1, d[1]);
    `CHK("ac4", 7'h13, ram_address_counter_q)
    wi(1'b0, 8'h92);
    u_lcdcmd_host.get(1'b1, q);
    u_lcdcmd_host.ready(s);
    `CHK("rd4", d[1], q)
    u_lcdcmd_host.put(1'b0, 8'h30);
    u_lcdcmd_host.w8 = 1'b1;
    u_lcdcmd_host.ready(s);
    `CHK("width8", 1'b1, interface_width_select_q)
    wrap_up;
  end
  // Watchdog: about four times the expected run
  initial begin
    #2000000;
    err_total++;
    wrap_up;
  end
endmodule
bind lcdcmd_top lcdcmd_monitor #(.EXEC_CYCLES(EXEC_CYCLES)) u_lcdcmd_monitor (.clk(clk), .srst(srst),
  .register_select(register_select), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata_q(bus_rdata_q), .busy_indicator_q(busy_indicator_q), .ram_address_counter_q(ram_address_counter_q),
  .interface_width_select_q(interface_width_select_q), .display_shift_q(display_shift_q),
  .two_line_q(two_line_q), .tall_font_q(tall_font_q), .duty_sel_q(duty_sel_q),
  .common_count_q(common_count_q), .common_active_q(common_active_q), .digit_count_q(digit_count_q));
`default_nettype wire
